/* File: lcd_top.sv */
/*
  Loop-code detection, remote loopback control, test-status flags and
  bipolar violation insertion, with an APB register slave and interrupt.
  Assumes receive and transmit strobes are synchronous to clk_i.
*/
// Implementation choices: register access over APB and the register addresses.
// Operation
// - Each low-to-high of the insert request inserts one bipolar violation.
// - Violation goes into QRSS pattern or single-rail user data.
// - Insert request sampled on each transmit clock rising edge.
// - Enable bits 01 and 10 select manual, 11 automatic detection.
// - Manual: flag set after loop code present over five seconds.
// - Manual: flag held while code present, cleared when it stops.
// - Entering automatic mode clears flag and watches for loop-up.
// - Auto: loop-up over five seconds sets flag and loopback together.
// - Auto: flag stays high while loopback is active.
// - Auto: loop-down over five seconds drops loopback and flag.
// - Alarm output follows the all-ones detector state.
// - Sync output follows the QRSS detector state.
// - Mode 10 watches loop-down only, mode 01 loop-up only.
`timescale 1ns/1ps
module lcd_top
  import lcd_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = lcd_pkg::PERSIST_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_clock_i,
  input wire logic violation_insert_req_i,
  input wire logic tx_data_i,
  input wire logic qrss_bit_i,
  output logic tx_pos_o,
  output logic tx_neg_o,
  input wire logic rx_bit_valid_i,
  input wire logic rx_data_i,
  input wire logic all_ones_det_i,
  input wire logic qrss_sync_det_i,
  output logic loop_code_flag_o,
  output logic remote_loopback_o,
  output logic all_ones_alarm_o,
  output logic test_pattern_sync_o,
  output logic irq_o
);
  import lcd_pkg::*;

  logic [3:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] events;
  lcd_mode_t mode;
  lcd_mode_t mode_q;
  lcd_auto_t auto_st;
  logic manual_flag;
  logic auto_flag;
  logic up_present;
  logic up_expired;
  logic dn_present;
  logic dn_expired;
  logic transmit_clock_q;
  logic ins_q;
  logic ins_pend;
  logic ins_edge;
  logic transmit_clock_rise;
  logic last_pos;
  logic tx_mark;
  logic mode_enter;
  logic flag_prev;
  logic lb_prev;
  logic ais_prev;
  logic sync_prev;
  logic apb_wr;
  logic apb_rd;

  assign mode = lcd_mode_t'({ctrl[CTRL_EN_HI], ctrl[CTRL_EN_LO]});
  assign mode_enter = (mode != mode_q);
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // Both timers always run; mode logic picks which one is watched
  lcd_persist #(
    .LEN(5),
    .CODE(LOOP_UP_CODE),
    .LIMIT(PERSIST_CYCLES),
    .CNT_W(CNT_W)
  ) u_up (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .restart_i(mode_enter),
    .bit_valid_i(rx_bit_valid_i),
    .bit_i(rx_data_i),
    .present_o(up_present),
    .expired_o(up_expired)
  );

  lcd_persist #(
    .LEN(3),
    .CODE({2'h0, LOOP_DOWN_CODE}),
    .LIMIT(PERSIST_CYCLES),
    .CNT_W(CNT_W)
  ) u_down (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .restart_i(mode_enter),
    .bit_valid_i(rx_bit_valid_i),
    .bit_i(rx_data_i),
    .present_o(dn_present),
    .expired_o(dn_expired)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= MODE_OFF;
    end else if (ce_i) begin
      mode_q <= mode;
    end
  end

  // Manual detection: flag is the live persistence result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      manual_flag <= 1'b0;
    end else if (ce_i) begin
      unique case (mode)
        MODE_DOWN: manual_flag <= dn_expired && dn_present && !mode_enter;
        MODE_UP: manual_flag <= up_expired && up_present && !mode_enter;
        MODE_OFF, MODE_AUTO: manual_flag <= 1'b0;
      endcase
    end
  end

  // Automatic detection with remote loopback
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_st <= AST_IDLE;
      auto_flag <= 1'b0;
    end else if (ce_i) begin
      if (mode != MODE_AUTO) begin
        auto_st <= AST_IDLE;
        auto_flag <= 1'b0;
      end else begin
        unique case (auto_st)
          AST_IDLE: begin
            auto_st <= AST_WAIT_UP;
            auto_flag <= 1'b0;
          end
          AST_WAIT_UP: begin
            if (up_expired) begin
              auto_st <= AST_LOOPED;
              auto_flag <= 1'b1;
            end
          end
          AST_LOOPED: begin
            if (dn_expired) begin
              auto_st <= AST_WAIT_UP;
              auto_flag <= 1'b0;
            end else begin
              auto_flag <= 1'b1;
            end
          end
          default: begin
            auto_st <= AST_IDLE;
            auto_flag <= 1'b0;
          end
        endcase
      end
    end
  end

  // Outputs and live status
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_code_flag_o <= 1'b0;
      remote_loopback_o <= 1'b0;
      all_ones_alarm_o <= 1'b0;
      test_pattern_sync_o <= 1'b0;
    end else if (ce_i) begin
      loop_code_flag_o <= manual_flag | auto_flag;
      remote_loopback_o <= auto_flag;
      all_ones_alarm_o <= all_ones_det_i;
      test_pattern_sync_o <= qrss_sync_det_i;
    end
  end

  // Transmit side: transmit_clock_i sampled as a synchronous input
  assign transmit_clock_rise = transmit_clock_i && !transmit_clock_q;
  assign ins_edge = transmit_clock_rise && violation_insert_req_i && !ins_q;
  assign tx_mark = ctrl[CTRL_QRSS_EN] ? qrss_bit_i : tx_data_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transmit_clock_q <= 1'b0;
      ins_q <= 1'b0;
    end else if (ce_i) begin
      transmit_clock_q <= transmit_clock_i;
      if (transmit_clock_rise) begin
        ins_q <= violation_insert_req_i;
      end
    end
  end

  // Violation placed on next mark; AMI polarity otherwise alternates
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ins_pend <= 1'b0;
      last_pos <= 1'b0;
      tx_pos_o <= 1'b0;
      tx_neg_o <= 1'b0;
    end else if (ce_i && transmit_clock_rise) begin
      tx_pos_o <= 1'b0;
      tx_neg_o <= 1'b0;
      // Refused requests must not linger and fire after a later mode change
      if (ins_edge && !tx_mark && (ctrl[CTRL_SINGLE_RAIL] || ctrl[CTRL_QRSS_EN])) begin
        ins_pend <= 1'b1;
      end else if (!(ctrl[CTRL_SINGLE_RAIL] || ctrl[CTRL_QRSS_EN])) begin
        ins_pend <= 1'b0;
      end
      if (tx_mark) begin
        if ((ins_pend || ins_edge) && (ctrl[CTRL_SINGLE_RAIL] || ctrl[CTRL_QRSS_EN])) begin
          tx_pos_o <= last_pos;
          tx_neg_o <= !last_pos;
          ins_pend <= 1'b0;
        end else begin
          tx_pos_o <= !last_pos;
          tx_neg_o <= last_pos;
          last_pos <= !last_pos;
        end
      end
    end
  end

  // Interrupt events; set wins over write-one-to-clear
  assign events = {ins_edge, test_pattern_sync_o ^ sync_prev, all_ones_alarm_o ^ ais_prev,
                   remote_loopback_o ^ lb_prev, loop_code_flag_o ^ flag_prev};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_prev <= 1'b0;
      lb_prev <= 1'b0;
      ais_prev <= 1'b0;
      sync_prev <= 1'b0;
      irq_stat <= '0;
    end else if (ce_i) begin
      flag_prev <= loop_code_flag_o;
      lb_prev <= remote_loopback_o;
      ais_prev <= all_ones_alarm_o;
      sync_prev <= test_pattern_sync_o;
      if (apb_wr && paddr == OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // APB slave: read data prepared in setup, pready high in access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RESET;
      irq_mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce_i) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == OFS_CTRL || paddr == OFS_STAT
                 || paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_MASK);
      if (apb_wr && pready) begin
        if (paddr == OFS_CTRL) begin
          ctrl <= pwdata[3:0];
        end
        if (paddr == OFS_IRQ_MASK) begin
          irq_mask <= pwdata[IRQ_W-1:0];
        end
      end
      if (apb_rd) begin
        unique case (paddr)
          OFS_CTRL: prdata <= {28'h0, ctrl};
          OFS_STAT: prdata <= {28'h0, test_pattern_sync_o, all_ones_alarm_o, remote_loopback_o,
                               loop_code_flag_o};
          OFS_IRQ_STAT: prdata <= {27'h0, irq_stat};
          OFS_IRQ_MASK: prdata <= {27'h0, irq_mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

/* File: lcd_pkg.sv */
/*
  Shared constants for the loop-code detect and test-flag block.
  Assumes a single 25 MHz clock domain.
*/
package lcd_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PERSIST_S = 5;
  localparam int unsigned PERSIST_CYC = PERSIST_S * CLK_HZ;
  localparam int unsigned CNT_W = 28;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  // Control fields
  localparam int CTRL_EN_LO = 0;
  localparam int CTRL_EN_HI = 1;
  localparam int CTRL_SINGLE_RAIL = 2;
  localparam int CTRL_QRSS_EN = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status and interrupt fields
  localparam int ST_FLAG = 0;
  localparam int ST_LOOPBACK = 1;
  localparam int ST_AIS = 2;
  localparam int ST_SYNC = 3;
  localparam int ST_BPV = 4;
  localparam int IRQ_W = 5;

  // Loop codes, sent repeatedly, newest bit in LSB
  localparam logic [4:0] LOOP_UP_CODE = 5'h01;
  localparam logic [2:0] LOOP_DOWN_CODE = 3'h1;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    // Field is {enable_hi, enable_lo}: high bit alone watches loop-down
    MODE_UP = 2'h1,
    MODE_DOWN = 2'h2,
    MODE_AUTO = 2'h3
  } lcd_mode_t;

  typedef enum logic [2:0] {
    AST_IDLE = 3'h1,
    AST_WAIT_UP = 3'h2,
    AST_LOOPED = 3'h4
  } lcd_auto_t;
endpackage

/* File: lcd_persist.sv */
/*
  Periodic-code persistence timer: reports when a repeating code has been
  seen without a break for longer than the limit.
  Assumes at most one bit per enabled clock cycle, marked by bit_valid_i.
*/
`timescale 1ns/1ps
module lcd_persist #(
  parameter int unsigned LEN = 5,
  parameter logic [4:0] CODE = 5'h01,
  parameter int unsigned LIMIT = 125000000,
  parameter int unsigned CNT_W = 28
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  output logic present_o,
  output logic expired_o
);
  logic [LEN-1:0] hist;
  logic [LEN-1:0] expect_hist;
  logic [2:0] fill;
  logic [CNT_W-1:0] cnt;
  logic match;

  // Pattern phase may be anything; accept any rotation of the code
  always_comb begin
    match = 1'b0;
    for (int r = 0; r < LEN; r++) begin
      expect_hist = LEN'((CODE[LEN-1:0] << r) | (CODE[LEN-1:0] >> (LEN - r)));
      if (hist == expect_hist) begin
        match = 1'b1;
      end
    end
    expect_hist = '0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist <= '0;
      fill <= 3'h0;
    end else if (ce_i && bit_valid_i) begin
      hist <= {hist[LEN-2:0], bit_i};
      if (fill != 3'(LEN)) begin
        fill <= fill + 3'h1;
      end
    end
  end

  // Count restarts on any break of the pattern
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      present_o <= 1'b0;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      present_o <= match && fill == 3'(LEN);
      if (restart_i || !(match && fill == 3'(LEN))) begin
        cnt <= '0;
        expired_o <= 1'b0;
      end else if (cnt < CNT_W'(LIMIT)) begin
        cnt <= cnt + CNT_W'(1);
      end else begin
        expired_o <= 1'b1;
      end
    end
  end
endmodule

/* File: lcd_monitor.sv */
/* Port checker for lcd_top, bound from the bench.
   Assumes one clock domain and the one-cycle output lag. */
`timescale 1ns/1ps
module lcd_monitor #(
  parameter int unsigned PERSIST_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_data_i,
  input wire logic transmit_clock_i,
  input wire logic tx_pos_o,
  input wire logic tx_neg_o,
  input wire logic all_ones_det_i,
  input wire logic qrss_sync_det_i,
  input wire logic loop_code_flag_o,
  input wire logic remote_loopback_o,
  input wire logic all_ones_alarm_o,
  input wire logic test_pattern_sync_o
);
  logic [31:0] up_cnt;
  logic [2:0] zero_run;
  // Five zero bits in a row fit neither code, so the persistence count restarts there
  // Saturates just past the limit, so no wrap on long runs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_cnt <= 32'h0;
      zero_run <= 3'h0;
    end else if (ce_i) begin
      if (rx_bit_valid_i) begin
        zero_run <= rx_data_i ? 3'h0 : (zero_run == 3'h5) ? zero_run : zero_run + 3'h1;
      end
      if (rx_bit_valid_i && !rx_data_i && zero_run >= 3'h4) begin
        up_cnt <= 32'h0;
      end else if (up_cnt <= PERSIST_CYCLES) begin
        up_cnt <= up_cnt + 32'h1;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence loop_on;
    !remote_loopback_o ##1 remote_loopback_o;
  endsequence
  sequence loop_off;
    remote_loopback_o ##1 !remote_loopback_o;
  endsequence
  ais_follow_a: assert property (ce_i |=> all_ones_alarm_o == $past(all_ones_det_i))
    else $error("alarm output lags its detector");
  sync_follow_a: assert property (ce_i |=> test_pattern_sync_o == $past(qrss_sync_det_i))
    else $error("sync output lags its detector");
  flag_held_a: assert property (remote_loopback_o |-> loop_code_flag_o)
    else $error("flag low during loopback");
  loop_enter_a: assert property (loop_on |-> loop_code_flag_o && !$past(loop_code_flag_o))
    else $error("loopback and flag not raised together");
  loop_leave_a: assert property (loop_off |-> !loop_code_flag_o)
    else $error("flag stays after loopback drop");
  flag_wait_a: assert property ($rose(loop_code_flag_o) |-> up_cnt > PERSIST_CYCLES)
    else $error("flag raised before persistence time");
  rail_timing_a: assert property (!$stable({tx_pos_o, tx_neg_o})
      |-> $past(transmit_clock_i) && !$past(transmit_clock_i, 2))
    else $error("rails moved without transmit clock rise");
  rail_excl_a: assert property (!(tx_pos_o && tx_neg_o))
    else $error("both rails marked");
endmodule

/* File: lcd_far_end.sv */
/* Far-end equipment model: repeats loop-up, loop-down or zeros, one bit per four clocks.
   Assumes code_i changes only from the bench clock edge. */
`timescale 1ns/1ps
module lcd_far_end (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] code_i,
  output logic valid_o,
  output logic bit_o
);
  logic [1:0] gap;
  logic [2:0] idx;
  logic [2:0] last;
  assign last = (code_i == 2'h2) ? 3'h2 : 3'h4;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 2'h0;
      idx <= 3'h0;
      valid_o <= 1'h0;
      bit_o <= 1'h0;
    end else begin
      gap <= gap + 2'h1;
      valid_o <= (gap == 2'h3);
      if (gap == 2'h3) begin
        bit_o <= (code_i != 2'h0) && (idx >= last);
        idx <= (idx >= last) ? 3'h0 : idx + 3'h1;
      end else begin
        // Between strobes the line carries nothing usable
        bit_o <= ~bit_o;
      end
    end
  end
endmodule

/* File: lcd_top_bench.sv */
/* Self-checking bench for lcd_top over APB with a far-end code source.
   Assumes lcd_pkg, lcd_monitor and lcd_far_end are compiled first. */
`timescale 1ns/1ps
module lcd_top_bench;
  import lcd_pkg::*;
  localparam int unsigned PC = 200;
  logic clk_i = 0;
  logic rst_n_i = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rv, rb, tpos, tneg, flag, lpb, ais_o, sync_o, irq_o;
  logic transmit_clock = 0, req = 0, txd = 0, qb = 0, ais = 0, sync = 0, ce = 1;
  logic [1:0] code = 2'h0;
  logic [4:0] p, n;
  int num_errors = 0;
  int tests_run = 0;
  always #20 clk_i = ~clk_i;
  lcd_top #(.PERSIST_CYCLES(PC)) dut (.clk_i, .rst_n_i, .ce_i(ce), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .transmit_clock_i(transmit_clock), .violation_insert_req_i(req),
    .tx_data_i(txd), .qrss_bit_i(qb), .tx_pos_o(tpos), .tx_neg_o(tneg), .rx_bit_valid_i(rv), .rx_data_i(rb),
    .all_ones_det_i(ais), .qrss_sync_det_i(sync), .loop_code_flag_o(flag), .remote_loopback_o(lpb),
    .all_ones_alarm_o(ais_o), .test_pattern_sync_o(sync_o), .irq_o);
  lcd_far_end far (.clk_i, .rst_n_i, .code_i(code), .valid_o(rv), .bit_o(rb));
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i) penable <= 1;
    do @(posedge clk_i); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    cyc(1);
  endtask
  task automatic st(logic [3:0] e);
    apb(0, OFS_STAT, 0);
    chk("stat", rd, e);
    chk("pins", {sync_o, ais_o, lpb, flag}, e);
  endtask
  task automatic mt(logic [1:0] m, logic [1:0] c, logic [3:0] e);
    apb(1, OFS_CTRL, m);
    code <= c;
    cyc(100);
    st(0);
    cyc(200);
    st(e);
    code <= 0;
    cyc(40);
    st(0);
  endtask
  task automatic bpv(logic [31:0] ctl);
    apb(1, OFS_CTRL, ctl);
    for (int i = 0; i < 5; i++) begin
      transmit_clock <= 0;
      cyc(2);
      transmit_clock <= 1;
      req <= (i == 2 || i == 3);
      cyc(3);
      p[i] = tpos;
      n[i] = tneg;
    end
    chk("rails", n, 5'(~p));
    chk("alternate", p[1] ^ p[0], 1);
    chk("violation", p[2] ^ p[1], 0);
    chk("single", {p[4] ^ p[3], p[3] ^ p[2]}, 3);
    req <= 0;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst_n_i <= 1;
    cyc(1);
    apb(0, OFS_CTRL, 0);
    chk("ctrl reset", rd, 0);
    apb(1, 8'h10, 32'h5);
    apb(0, 8'h10, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    ais <= 1;
    cyc(3);
    st(4'h4);
    apb(0, OFS_IRQ_STAT, 0);
    chk("irq stat", rd, 32'h4);
    chk("irq masked", irq_o, 0);
    apb(1, OFS_IRQ_MASK, 32'h4);
    cyc(2);
    chk("irq on", irq_o, 1);
    apb(1, OFS_IRQ_STAT, 32'h4);
    cyc(2);
    chk("irq clear", irq_o, 0);
    ais <= 0;
    sync <= 1;
    cyc(3);
    st(4'h8);
    ce <= 0;
    sync <= 0;
    cyc(3);
    chk("ce freeze", sync_o, 1);
    ce <= 1;
    // Code 1 sends loop-up, code 2 loop-down
    mt(2'h2, 2'h2, 4'h1);
    mt(2'h2, 2'h1, 4'h0);
    mt(2'h1, 2'h1, 4'h1);
    mt(2'h1, 2'h2, 4'h0);
    apb(1, OFS_CTRL, 1);
    code <= 1;
    cyc(300);
    apb(1, OFS_CTRL, 3);
    cyc(2);
    st(0);
    cyc(300);
    st(4'h3);
    code <= 0;
    cyc(300);
    st(4'h3);
    code <= 2;
    cyc(100);
    st(4'h3);
    cyc(200);
    st(0);
    code <= 0;
    txd <= 1;
    bpv(32'h4);
    txd <= 0;
    qb <= 1;
    bpv(32'h8);
    conclude();
  end
  initial begin
    cyc(10000);
    num_errors++;
    conclude();
  end
endmodule
bind lcd_top lcd_monitor #(.PERSIST_CYCLES(PERSIST_CYCLES)) mon (.clk_i, .rst_n_i, .ce_i, .rx_bit_valid_i,
  .rx_data_i, .transmit_clock_i,
  .tx_pos_o, .tx_neg_o, .all_ones_det_i, .qrss_sync_det_i, .loop_code_flag_o, .remote_loopback_o,
  .all_ones_alarm_o, .test_pattern_sync_o);
